// >>> inc/card_host_pkg.sv
// shared constants, register map and carrier types for the card host status block
package card_host_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 40; // 25 MHz system clock
	localparam int RESET_TIME_NS = 640; // least length of the internal reset
	localparam int RESET_CYCLES_RAW = (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESET_CYCLES = (RESET_CYCLES_RAW < 1) ? 1 : RESET_CYCLES_RAW;
	localparam int RESET_CNT_W = 5; // wide enough for the reset count
	localparam logic [RESET_CNT_W-1:0] RESET_LAST = RESET_CNT_W'(RESET_CYCLES - 1);
	localparam logic [RESET_CNT_W-1:0] RESET_CNT_ZERO = 5'h00;

	// ----------------------------------------------------------------
	// register map, byte addresses
	// ----------------------------------------------------------------
	localparam int ADDR_W = 5;
	localparam logic [ADDR_W-1:0] ADDR_COMMAND = 5'h00; // clock_and_operation_command
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h04; // card_host_status
	localparam logic [ADDR_W-1:0] ADDR_DIVIDER = 5'h08; // card_clock_divider
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 5'h0C; // sticky event bits
	localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 5'h10; // event enables

	// ----------------------------------------------------------------
	// command word fields
	// ----------------------------------------------------------------
	localparam int CMD_CLOCK_LSB = 0; // two-bit clock control code
	localparam int CMD_START_OP_BIT = 2;
	localparam int CMD_RESET_BIT = 3;
	localparam logic [1:0] CLOCK_CODE_STOP = 2'h1;
	localparam logic [1:0] CLOCK_CODE_START = 2'h2;

	// ----------------------------------------------------------------
	// divider and fifo levels
	// ----------------------------------------------------------------
	localparam int DIV_SEL_W = 3;
	localparam int DIV_CNT_W = 7; // largest division is 2**7
	localparam logic [DIV_CNT_W-1:0] DIV_CNT_ZERO = 7'h00;
	localparam logic [DIV_CNT_W-1:0] DIV_CNT_ONE = 7'h01;
	localparam int FIFO_COUNT_W = 5;
	localparam logic [FIFO_COUNT_W-1:0] FIFO_DEPTH = 5'h10;
	localparam logic [FIFO_COUNT_W-1:0] FIFO_AFULL_LEVEL = 5'h0F;
	localparam logic [FIFO_COUNT_W-1:0] FIFO_EMPTY_LEVEL = 5'h00;

	// ----------------------------------------------------------------
	// reset values and write-crc codes
	// ----------------------------------------------------------------
	localparam logic [31:0] STATUS_RESET = 32'h0000_0040;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	localparam logic [1:0] WCRC_OK = 2'h0;
	localparam logic [1:0] WCRC_BAD = 2'h1;
	localparam logic [1:0] WCRC_NONE = 2'h2;

	// status word layout, also the layout of irq status and mask
	typedef struct packed {
		logic [15:0] reserved;
		logic reset_in_progress;
		logic sdio_int_active;
		logic programming_finished;
		logic data_transfer_done;
		logic command_sequence_finished;
		logic fifo_almost_full;
		logic card_in_read_wait;
		logic clock_enabled;
		logic fifo_full;
		logic fifo_empty;
		logic response_check_error;
		logic read_check_error;
		logic [1:0] write_check_status;
		logic response_timeout;
		logic read_timeout;
	} card_host_status_t;

	// reports from the command, data and fifo logic, same clock
	typedef struct packed {
		logic cmd_done; // pulse: command sequence finished
		logic data_done; // pulse: data transfer finished
		logic resp_crc_err; // pulse: response crc failed
		logic read_crc_err; // pulse: read data crc failed
		logic wcrc_valid; // pulse: write crc status arrived
		logic [1:0] wcrc_code; // code that goes with wcrc_valid
		logic resp_timeout; // pulse: response timed out
		logic read_timeout; // pulse: read data timed out
		logic sdio_ack; // pulse: acknowledge command sent to card
		logic read_wait; // level: card is in read wait
		logic [FIFO_COUNT_W-1:0] fifo_count; // words held in data fifo
	} ctl_events_t;

	// avalon-mm request group from the master
	typedef struct packed {
		logic read;
		logic write;
		logic [ADDR_W-1:0] address;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} av_req_t;

endpackage

// >>> hdl/card_host_status_and_clock_divider.sv
// status word, card clock divider and interrupt logic of the card host controller
`timescale 1ns/10ps

module card_host_status_and_clock_divider
(
	input wire logic clk,
	input wire logic rst,
	input wire card_host_pkg::av_req_t av_req,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire card_host_pkg::ctl_events_t ctl_ev,
	input wire logic card_dat0,
	input wire logic sdio_irq_n,
	output logic card_clk_tick,
	output logic ctl_reset,
	output logic start_op,
	output logic irq
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic waitrequest_ff; // low for exactly one cycle per transfer
	logic [31:0] readdata_ff; // captured when waitrequest drops
	logic rd_acc; // read completes at this edge
	logic wr_acc; // write takes effect at this edge
	logic cmd_wr; // command word written
	logic soft_reset_req; // reset bit written as 1
	logic start_op_req; // start bit written as 1
	logic [1:0] clock_code; // clock control code of a command write
	logic resetting_ff; // internal reset in progress
	logic [card_host_pkg::RESET_CNT_W-1:0] reset_cnt_ff; // reset length counter
	logic clk_on_ff; // card clock running
	logic [card_host_pkg::DIV_SEL_W-1:0] div_sel_ff; // card_clock_divider select
	logic [card_host_pkg::DIV_CNT_W-1:0] div_cnt_ff; // source clock counter
	logic tick_ff; // one card clock period per tick
	logic dat0_s1_ff; // pin synchroniser, first stage
	logic dat0_s2_ff; // pin synchroniser, second stage
	logic irq_s1_ff; // pin synchroniser, first stage
	logic irq_s2_ff; // pin synchroniser, second stage
	card_host_pkg::card_host_status_t status_ff; // card_host_status
	card_host_pkg::card_host_status_t nxt_status; // next status value
	card_host_pkg::card_host_status_t ev_word; // events in status layout
	logic [31:0] irq_status_ff; // sticky event bits
	logic [31:0] irq_mask_ff; // event enables
	logic [31:0] irq_clear; // bits an irq status read returned
	logic irq_ff; // level interrupt
	logic start_op_ff; // one-cycle start pulse to controller
	logic [31:0] rd_value; // read mux

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	// low-bit mask of the counter that must be all ones for a tick
	function automatic logic [card_host_pkg::DIV_CNT_W-1:0] div_mask
	(
		input logic [card_host_pkg::DIV_SEL_W-1:0] sel
	);
		logic [card_host_pkg::DIV_CNT_W:0] one_hot;
		one_hot = (card_host_pkg::DIV_CNT_W+1)'(1) << sel;
		return card_host_pkg::DIV_CNT_W'(one_hot - (card_host_pkg::DIV_CNT_W+1)'(1));
	endfunction

	// ----------------------------------------------------------------
	// avalon-mm slave
	// ----------------------------------------------------------------
	assign rd_acc = av_req.read && !waitrequest_ff;
	assign wr_acc = av_req.write && !waitrequest_ff;
	assign cmd_wr = wr_acc && (av_req.address == card_host_pkg::ADDR_COMMAND)
		&& av_req.byteenable[0];
	assign soft_reset_req = cmd_wr && av_req.writedata[card_host_pkg::CMD_RESET_BIT];
	assign start_op_req = cmd_wr && av_req.writedata[card_host_pkg::CMD_START_OP_BIT];
	assign clock_code = av_req.writedata[card_host_pkg::CMD_CLOCK_LSB +: 2];

	// one wait cycle, then a single ready cycle; never two in a row
	always_ff @(posedge clk)
	begin
		if (rst)
			waitrequest_ff <= 1'b1;
		else if ((av_req.read || av_req.write) && waitrequest_ff)
			waitrequest_ff <= 1'b0;
		else
			waitrequest_ff <= 1'b1;
	end

	// read mux; unmapped and write-only words read as zero
	always_comb
	begin
		rd_value = card_host_pkg::WORD_ZERO;
		case (av_req.address)
			card_host_pkg::ADDR_STATUS: rd_value = status_ff;
			card_host_pkg::ADDR_DIVIDER: rd_value = 32'(div_sel_ff);
			card_host_pkg::ADDR_IRQ_STATUS: rd_value = irq_status_ff;
			card_host_pkg::ADDR_IRQ_MASK: rd_value = irq_mask_ff;
			default: rd_value = card_host_pkg::WORD_ZERO;
		endcase
	end

	// read data is caught as waitrequest drops and stands for that cycle
	always_ff @(posedge clk)
	begin
		if (rst)
			readdata_ff <= card_host_pkg::WORD_ZERO;
		else if (av_req.read && waitrequest_ff)
			readdata_ff <= rd_value;
	end

	AST_ONE_READY: assert property (@(posedge clk) disable iff (rst)
		!waitrequest_ff |=> waitrequest_ff)
		else $error("waitrequest low for more than one cycle");

	// ----------------------------------------------------------------
	// internal reset sequencer
	// ----------------------------------------------------------------
	// runs after power-up reset and after a software reset request
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			resetting_ff <= 1'b1;
			reset_cnt_ff <= card_host_pkg::RESET_CNT_ZERO;
		end
		else if (soft_reset_req)
		begin
			resetting_ff <= 1'b1;
			reset_cnt_ff <= card_host_pkg::RESET_CNT_ZERO;
		end
		else if (resetting_ff)
		begin
			if (reset_cnt_ff == card_host_pkg::RESET_LAST)
				resetting_ff <= 1'b0;
			reset_cnt_ff <= reset_cnt_ff + 1'b1;
		end
	end

	AST_SOFT_RESET: assert property (@(posedge clk) disable iff (rst)
		(soft_reset_req && !resetting_ff) |=> resetting_ff && status_ff.reset_in_progress == 1'b0
		##1 status_ff.reset_in_progress)
		else $error("software reset did not raise the resetting flag");

	AST_RESET_END: assert property (@(posedge clk) disable iff (rst)
		(resetting_ff && reset_cnt_ff == card_host_pkg::RESET_LAST && !soft_reset_req)
		|=> !resetting_ff ##1 !status_ff.reset_in_progress)
		else $error("resetting flag not cleared at end of reset");

	// ----------------------------------------------------------------
	// card clock control and divider
	// ----------------------------------------------------------------
	// start/stop command; code 00 and 11 leave the clock alone
	always_ff @(posedge clk)
	begin
		if (rst)
			clk_on_ff <= 1'b0;
		else if (resetting_ff)
			clk_on_ff <= 1'b0;
		else if (cmd_wr && clock_code == card_host_pkg::CLOCK_CODE_START)
			clk_on_ff <= 1'b1;
		else if (cmd_wr && clock_code == card_host_pkg::CLOCK_CODE_STOP)
			clk_on_ff <= 1'b0;
	end

	// divider select, set by software, cleared to zero by the internal reset
	always_ff @(posedge clk)
	begin
		if (rst)
			div_sel_ff <= '0;
		else if (resetting_ff)
			div_sel_ff <= '0;
		else if (wr_acc && av_req.address == card_host_pkg::ADDR_DIVIDER
			&& av_req.byteenable[0])
			div_sel_ff <= av_req.writedata[card_host_pkg::DIV_SEL_W-1:0];
	end

	// tick every 2**sel source cycles; a gated-clock cell downstream
	// uses it, since a flop cannot pass the source clock through itself
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			div_cnt_ff <= card_host_pkg::DIV_CNT_ZERO;
			tick_ff <= 1'b0;
		end
		else if (!clk_on_ff)
		begin
			div_cnt_ff <= card_host_pkg::DIV_CNT_ZERO;
			tick_ff <= 1'b0;
		end
		else
		begin
			div_cnt_ff <= div_cnt_ff + card_host_pkg::DIV_CNT_ONE;
			tick_ff <= (div_cnt_ff & div_mask(div_sel_ff)) == div_mask(div_sel_ff);
		end
	end

	AST_DIV_ONE: assert property (@(posedge clk) disable iff (rst)
		($past(clk_on_ff) && $past(div_sel_ff) == 3'h0) |-> tick_ff)
		else $error("divide-by-one clock missed a tick");

	AST_DIV_TWO: assert property (@(posedge clk) disable iff (rst)
		(tick_ff && clk_on_ff && div_sel_ff == 3'h1 && $stable(div_sel_ff))
		|=> !tick_ff)
		else $error("divide-by-two clock ticked twice in a row");

	AST_CLK_START: assert property (@(posedge clk) disable iff (rst)
		(cmd_wr && clock_code == card_host_pkg::CLOCK_CODE_START && !resetting_ff
		&& !soft_reset_req)
		|=> ##1 status_ff.clock_enabled)
		else $error("clock start not shown in status");

	AST_CLK_STOP: assert property (@(posedge clk) disable iff (rst)
		(cmd_wr && clock_code == card_host_pkg::CLOCK_CODE_STOP)
		|=> !clk_on_ff ##1 !tick_ff)
		else $error("clock stop did not stop the card clock");

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	// card busy (data line 0 low) and sdio interrupt come from the card
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			// idle level of the line: card not busy
			dat0_s1_ff <= 1'b1;
			dat0_s2_ff <= 1'b1;
			irq_s1_ff <= 1'b1;
			irq_s2_ff <= 1'b1;
		end
		else
		begin
			dat0_s1_ff <= card_dat0;
			dat0_s2_ff <= dat0_s1_ff;
			irq_s1_ff <= sdio_irq_n;
			irq_s2_ff <= irq_s1_ff;
		end
	end

	// ----------------------------------------------------------------
	// status word
	// ----------------------------------------------------------------
	// a new operation clears the completion and error flags; an event
	// in the same cycle still wins over that clear
	always_comb
	begin
		nxt_status = status_ff;
		nxt_status.reserved = '0;
		nxt_status.reset_in_progress = resetting_ff;
		if (start_op_req)
		begin
			nxt_status.command_sequence_finished = 1'b0;
			nxt_status.data_transfer_done = 1'b0;
			nxt_status.response_check_error = 1'b0;
			nxt_status.read_check_error = 1'b0;
			nxt_status.write_check_status = card_host_pkg::WCRC_OK;
			nxt_status.response_timeout = 1'b0;
			nxt_status.read_timeout = 1'b0;
		end
		if (ctl_ev.cmd_done)
			nxt_status.command_sequence_finished = 1'b1;
		if (ctl_ev.data_done)
			nxt_status.data_transfer_done = 1'b1;
		if (ctl_ev.resp_crc_err)
			nxt_status.response_check_error = 1'b1;
		if (ctl_ev.read_crc_err)
			nxt_status.read_check_error = 1'b1;
		if (ctl_ev.wcrc_valid)
			nxt_status.write_check_status = ctl_ev.wcrc_code;
		if (ctl_ev.resp_timeout)
			nxt_status.response_timeout = 1'b1;
		if (ctl_ev.read_timeout)
			nxt_status.read_timeout = 1'b1;
		// interrupt held until acknowledge; a live request wins
		if (ctl_ev.sdio_ack)
			nxt_status.sdio_int_active = 1'b0;
		if (!irq_s2_ff)
			nxt_status.sdio_int_active = 1'b1;
		nxt_status.programming_finished = dat0_s2_ff;
		nxt_status.card_in_read_wait = ctl_ev.read_wait;
		nxt_status.clock_enabled = clk_on_ff;
		// full is exact: while software drains it seldom reaches it
		nxt_status.fifo_full = ctl_ev.fifo_count >= card_host_pkg::FIFO_DEPTH;
		nxt_status.fifo_almost_full = ctl_ev.fifo_count >= card_host_pkg::FIFO_AFULL_LEVEL;
		nxt_status.fifo_empty = ctl_ev.fifo_count == card_host_pkg::FIFO_EMPTY_LEVEL;
		if (resetting_ff)
		begin
			nxt_status = card_host_pkg::STATUS_RESET;
			nxt_status.reset_in_progress = 1'b1;
		end
	end

	// status register, empty flag set out of reset
	always_ff @(posedge clk)
	begin
		if (rst)
			status_ff <= card_host_pkg::STATUS_RESET;
		else
			status_ff <= nxt_status;
	end

	AST_SDIO_HOLD: assert property (@(posedge clk) disable iff (rst)
		(status_ff.sdio_int_active && !ctl_ev.sdio_ack && !resetting_ff)
		|=> status_ff.sdio_int_active)
		else $error("sdio interrupt flag dropped without acknowledge");

	AST_PROGRAMMING_FINISHED: assert property (@(posedge clk) disable iff (rst)
		(!resetting_ff && !$past(resetting_ff) && !$past(rst, 3))
		|=> status_ff.programming_finished == $past(card_dat0, 3))
		else $error("programming flag does not follow card busy");

	AST_DONE_SET: assert property (@(posedge clk) disable iff (rst)
		((ctl_ev.data_done || ctl_ev.cmd_done) && !resetting_ff)
		|=> (status_ff.data_transfer_done || !$past(ctl_ev.data_done))
		&& (status_ff.command_sequence_finished || !$past(ctl_ev.cmd_done)))
		else $error("completion flag not set");

	AST_CMD_STICKY: assert property (@(posedge clk) disable iff (rst)
		(status_ff.command_sequence_finished && !start_op_req && !resetting_ff)
		|=> status_ff.command_sequence_finished)
		else $error("command finished flag lost");

	AST_FIFO_LEVELS: assert property (@(posedge clk) disable iff (rst)
		!resetting_ff |=> status_ff.fifo_almost_full
		== ($past(ctl_ev.fifo_count) >= card_host_pkg::FIFO_AFULL_LEVEL)
		&& status_ff.fifo_empty == ($past(ctl_ev.fifo_count) == 5'h00))
		else $error("fifo level flags wrong");

	AST_FIFO_FULL: assert property (@(posedge clk) disable iff (rst)
		(!resetting_ff && ctl_ev.fifo_count == card_host_pkg::FIFO_DEPTH)
		|=> status_ff.fifo_full && status_ff.fifo_almost_full && !status_ff.fifo_empty)
		else $error("fifo full flag wrong");

	AST_ERR_SET: assert property (@(posedge clk) disable iff (rst)
		(!resetting_ff && (ctl_ev.resp_crc_err || ctl_ev.read_crc_err))
		|=> (status_ff.response_check_error || status_ff.read_check_error)
		&& status_ff.response_check_error == $past(ctl_ev.resp_crc_err)
		|| $past(status_ff.response_check_error) && !$past(start_op_req))
		else $error("crc error flag wrong");

	AST_WCRC: assert property (@(posedge clk) disable iff (rst)
		(!resetting_ff && ctl_ev.wcrc_valid)
		|=> status_ff.write_check_status == $past(ctl_ev.wcrc_code))
		else $error("write crc status not loaded");

	AST_TIMEOUTS: assert property (@(posedge clk) disable iff (rst)
		(!resetting_ff && (ctl_ev.resp_timeout || ctl_ev.read_timeout))
		|=> (status_ff.response_timeout || !$past(ctl_ev.resp_timeout))
		&& (status_ff.read_timeout || !$past(ctl_ev.read_timeout)))
		else $error("timeout flags not set");

	// ----------------------------------------------------------------
	// interrupt status, mask and output
	// ----------------------------------------------------------------
	// events shaped like the status word: event pulses as they come, rising edges of the sdio and programming flags
	always_comb
	begin
		ev_word = '0;
		ev_word.sdio_int_active = nxt_status.sdio_int_active && !status_ff.sdio_int_active;
		// the flag is forced low in reset; its rise just after is no event
		ev_word.programming_finished = nxt_status.programming_finished
			&& !status_ff.programming_finished && !status_ff.reset_in_progress;
		ev_word.data_transfer_done = ctl_ev.data_done;
		ev_word.command_sequence_finished = ctl_ev.cmd_done;
		ev_word.response_check_error = ctl_ev.resp_crc_err;
		ev_word.read_check_error = ctl_ev.read_crc_err;
		ev_word.write_check_status = ctl_ev.wcrc_valid ? ctl_ev.wcrc_code : 2'h0;
		ev_word.response_timeout = ctl_ev.resp_timeout;
		ev_word.read_timeout = ctl_ev.read_timeout;
	end

	// a read clears only the bits it returned, so late events survive
	assign irq_clear = (rd_acc && av_req.address == card_host_pkg::ADDR_IRQ_STATUS)
		? readdata_ff : card_host_pkg::WORD_ZERO;

	always_ff @(posedge clk)
	begin
		if (rst)
			irq_status_ff <= card_host_pkg::WORD_ZERO;
		else if (resetting_ff)
			irq_status_ff <= card_host_pkg::WORD_ZERO;
		else
			irq_status_ff <= (irq_status_ff & ~irq_clear) | ev_word;
	end

	// mask register, same layout as status
	always_ff @(posedge clk)
	begin
		if (rst)
			irq_mask_ff <= card_host_pkg::WORD_ZERO;
		else if (resetting_ff)
			irq_mask_ff <= card_host_pkg::WORD_ZERO;
		else if (wr_acc && av_req.address == card_host_pkg::ADDR_IRQ_MASK)
			irq_mask_ff <= av_req.writedata;
	end

	// registered level; trails the status bits by one cycle
	always_ff @(posedge clk)
	begin
		if (rst)
			irq_ff <= 1'b0;
		else
			irq_ff <= |(irq_status_ff & irq_mask_ff);
	end

	// start pulse handed to the command logic
	always_ff @(posedge clk)
	begin
		if (rst)
			start_op_ff <= 1'b0;
		else
			start_op_ff <= start_op_req && !resetting_ff;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign readdata = readdata_ff;
	assign waitrequest = waitrequest_ff;
	assign card_clk_tick = tick_ff;
	assign ctl_reset = resetting_ff;
	assign start_op = start_op_ff;
	assign irq = irq_ff;

endmodule // card_host_status_and_clock_divider

// >>> verif/card_model.sv
// card-side model driving the data-0 busy line and the interrupt pin
`timescale 1ns/10ps
module card_model
(
	input wire logic busy,
	input wire logic irq_on,
	output logic card_dat0,
	output logic sdio_irq_n
);
	// ----------------------------------------------------------------
	// pins
	// ----------------------------------------------------------------
	// card pulls data 0 low while programming
	assign card_dat0 = !busy;
	// card holds its interrupt low while the bench drives irq_on; the bench lets it go before ack
	assign sdio_irq_n = !irq_on;
endmodule // card_model

// >>> verif/card_host_status_and_clock_divider_test.sv
// self-checking bench for the card host status and clock divider block
`timescale 1ns/10ps
module card_host_status_and_clock_divider_test;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic clk;
	logic rst;
	card_host_pkg::av_req_t av_req;
	logic [31:0] readdata;
	logic waitrequest;
	card_host_pkg::ctl_events_t ctl_ev;
	logic card_dat0;
	logic sdio_irq_n;
	logic card_clk_tick;
	logic ctl_reset;
	logic start_op;
	logic irq;
	logic busy;
	logic irq_on;
	logic [31:0] q;
	int fails;
	int total_checks;
	int ticks;
	int ops;
	int t0;
	// idle status: card not busy, fifo empty
	localparam logic [31:0] BASE = 32'h0000_2040;
	localparam logic [15:0] EV [8] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000,
		16'h0100, 16'h0080, 16'h0A00, 16'h0C00};
	localparam logic [31:0] ST [8] = '{32'h800, 32'h1000, 32'h20, 32'h10, 32'h2, 32'h1,
		32'h4, 32'h8};
	card_host_status_and_clock_divider uut (.clk(clk), .rst(rst), .av_req(av_req),
		.readdata(readdata), .waitrequest(waitrequest), .ctl_ev(ctl_ev),
		.card_dat0(card_dat0), .sdio_irq_n(sdio_irq_n), .card_clk_tick(card_clk_tick),
		.ctl_reset(ctl_reset), .start_op(start_op), .irq(irq));
	card_model card (.busy(busy), .irq_on(irq_on), .card_dat0(card_dat0),
		.sdio_irq_n(sdio_irq_n));
	// ----------------------------------------------------------------
	// clock, counters and watchdog
	// ----------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// ticks and start pulses counted at every rising edge
	always @(posedge clk)
	begin
		ticks <= ticks + int'(card_clk_tick === 1'b1);
		ops <= ops + int'(start_op === 1'b1);
	end
	// run needs well under 5000 cycles
	initial
	begin
		repeat (20000) @(posedge clk);
		fails++;
		tally_and_finish();
	end
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// one avalon transfer; held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		av_req <= '{!w, w, a, d, 4'hF};
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (waitrequest !== 1'b0 && k < 50);
		if (k >= 50)
			fails++;
		q = readdata;
		av_req <= '0;
	endtask
	// one-cycle event pulse; level fields are kept
	task automatic pulse(input logic [15:0] m);
		@(posedge clk);
		ctl_ev <= ctl_ev | m;
		@(posedge clk);
		ctl_ev <= ctl_ev & 16'h003F;
		repeat (2) @(posedge clk);
	endtask
	// wait for the internal reset to finish, bounded
	task automatic settle();
		int k;
		k = 0;
		while (ctl_reset !== 1'b0 && k < 100)
		begin
			@(posedge clk);
			k++;
		end
		chk("reset_len", 32'(k < 100), 32'h1);
		repeat (3) @(posedge clk);
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		rst = 1'b1;
		av_req = '0;
		ctl_ev = '0;
		busy = 1'b0;
		irq_on = 1'b0;
		fails = 0;
		total_checks = 0;
		ticks = 0;
		ops = 0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		bus(1'b0, card_host_pkg::ADDR_STATUS, 32'h0);
		chk("resetting", q & 32'h8000, 32'h8000);
		settle();
		bus(1'b0, card_host_pkg::ADDR_STATUS, 32'h0);
		chk("status_idle", q, BASE);
		// every event flag, then cleared by a start-op write with clock code 00
		for (int i = 0; i < 8; i++)
		begin
			pulse(EV[i]);
			bus(1'b0, card_host_pkg::ADDR_STATUS, 32'h0);
			chk("event", q, BASE | ST[i]);
			bus(1'b1, card_host_pkg::ADDR_COMMAND, 32'h4);
			bus(1'b0, card_host_pkg::ADDR_STATUS, 32'h0);
			chk("cleared", q, BASE);
		end
		chk("start_ops", 32'(ops), 32'h8);
		// fifo levels around the almost-full and full boundaries
		foreach (ST[i])
		begin
			if (i > 3)
				break;
			ctl_ev.fifo_count <= 5'(i == 0 ? 0 : 13 + i);
			bus(1'b0, card_host_pkg::ADDR_STATUS, 32'h0);
			chk("fifo", q & 32'h4C0, i == 0 ? 32'h40 : i == 1 ? 32'h0 :
				i == 2 ? 32'h400 : 32'h480);
		end
		ctl_ev.read_wait <= 1'b1;
		bus(1'b0, card_host_pkg::ADDR_STATUS, 32'h0);
		chk("read_wait", q & 32'h7C0, 32'h680);
		ctl_ev <= '0;
		// card interrupt held past release until acknowledge
		irq_on <= 1'b1;
		busy <= 1'b1;
		repeat (5) @(posedge clk);
		irq_on <= 1'b0;
		busy <= 1'b0;
		bus(1'b0, card_host_pkg::ADDR_STATUS, 32'h0);
		chk("sdio_busy", q & 32'h6000, 32'h4000);
		repeat (5) @(posedge clk);
		bus(1'b0, card_host_pkg::ADDR_STATUS, 32'h0);
		chk("sdio_held", q & 32'h6000, 32'h6000);
		pulse(16'h0040);
		bus(1'b0, card_host_pkg::ADDR_STATUS, 32'h0);
		chk("sdio_ack", q, BASE);
		// every divider code: ticks in 128 source cycles
		bus(1'b1, card_host_pkg::ADDR_COMMAND, 32'h2);
		bus(1'b0, card_host_pkg::ADDR_STATUS, 32'h0);
		chk("clk_on", q, BASE | 32'h100);
		for (int s = 0; s < 8; s++)
		begin
			bus(1'b1, card_host_pkg::ADDR_DIVIDER, 32'(s));
			bus(1'b0, card_host_pkg::ADDR_DIVIDER, 32'h0);
			chk("divider", q, 32'(s));
			repeat (140) @(posedge clk);
			t0 = ticks;
			repeat (128) @(posedge clk);
			chk("ticks", 32'(ticks - t0), 32'(128 >> s));
		end
		bus(1'b1, card_host_pkg::ADDR_COMMAND, 32'h1);
		bus(1'b0, card_host_pkg::ADDR_STATUS, 32'h0);
		t0 = ticks;
		repeat (200) @(posedge clk);
		chk("clk_off", q | 32'(ticks - t0), BASE);
		// interrupt raised, read-cleared, then masked
		bus(1'b0, card_host_pkg::ADDR_IRQ_STATUS, 32'h0);
		bus(1'b1, card_host_pkg::ADDR_IRQ_MASK, 32'h800);
		pulse(16'h8000);
		chk("irq_on", 32'(irq), 32'h1);
		bus(1'b0, card_host_pkg::ADDR_IRQ_STATUS, 32'h0);
		chk("irq_bit", q & 32'h800, 32'h800);
		repeat (3) @(posedge clk);
		chk("irq_off", 32'(irq), 32'h0);
		bus(1'b1, card_host_pkg::ADDR_IRQ_MASK, 32'h0);
		pulse(16'h8000);
		chk("irq_masked", 32'(irq), 32'h0);
		// unmapped and read-only places
		bus(1'b0, 5'h14, 32'h0);
		chk("unmapped", q, 32'h0);
		bus(1'b1, card_host_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
		bus(1'b1, card_host_pkg::ADDR_DIVIDER, 32'h5);
		// software reset clears divider and flags
		bus(1'b1, card_host_pkg::ADDR_COMMAND, 32'h8);
		bus(1'b0, card_host_pkg::ADDR_STATUS, 32'h0);
		chk("sw_resetting", q & 32'h8000, 32'h8000);
		settle();
		bus(1'b0, card_host_pkg::ADDR_STATUS, 32'h0);
		chk("sw_status", q, BASE);
		bus(1'b0, card_host_pkg::ADDR_DIVIDER, 32'h0);
		chk("sw_divider", q, 32'h0);
		bus(1'b0, card_host_pkg::ADDR_IRQ_STATUS, 32'h0);
		chk("sw_irq_status", q, 32'h0);
		tally_and_finish();
	end
endmodule // card_host_status_and_clock_divider_test
